// >>> batt_chg_pkg.sv
// Constants, types and field layout for the charging and port power block.
// Assumes a single 125 MHz core clock and a byte-wide parallel configuration port.
//
// Summary of operation
// - Charger detection starts automatically on entering the charger detect stage.
// - Contact detect phase times out after 200 ms, within 199 to 204 ms.
// - Each downstream port can be configured for charging on its own.
// - Port role is fixed at configuration and never changes afterwards.
// - Charging queries get only a positive acknowledge, and only on charging ports.
// - Charging logic, not hub logic, drives power enable of charging ports.
// - Charging ports get power enable once hub configuration has completed.
// - Overcurrent under charging control drops power enable until device reset.
// - After enumeration, hub logic regains power control and host must enable it.
// - Port power feature 1 selects hub logic, 0 selects charging logic for charging ports only.
// - Overcurrent always clears power enable, whichever logic controls it.
// - Charge enable bit 1 is port 1, bit 2 port 2; bit 0 unused.
// - Setting a port's charge enable bit before configuration completes asserts its power enable when it completes.
package batt_chg_pkg;

	// -------------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------------
	localparam logic [7:0] CHARGE_PORT_ENABLE_ADDR  = 8'hd0;
	localparam logic [7:0] CHARGE_PORT_ENABLE_RESET = 8'h00;
	localparam int         FIRST_PORT_BIT           = 1;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int unsigned CORE_CLK_HZ            = 125_000_000;
	localparam int unsigned CYC_PER_MS             = CORE_CLK_HZ / 1000;
	localparam int unsigned CONTACT_DETECT_TIMEOUT_MS = 200;
	localparam int unsigned SOURCE_SINK_ON_TIME_MS    = 80;
	localparam int unsigned DETECT_TO_END_DELAY_MS    = 80;
	localparam int unsigned DISABLED_EXIT_TIME_MS     = 50;
	localparam int unsigned CONTACT_DETECT_TIMEOUT_CYC = CONTACT_DETECT_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned SOURCE_SINK_ON_TIME_CYC    = SOURCE_SINK_ON_TIME_MS * CYC_PER_MS;
	localparam int unsigned DETECT_TO_END_DELAY_CYC    = DETECT_TO_END_DELAY_MS * CYC_PER_MS;
	localparam int unsigned DISABLED_EXIT_TIME_CYC     = DISABLED_EXIT_TIME_MS * CYC_PER_MS;
	localparam int          TIMER_W                    = 32;

	// -------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------
	typedef enum logic [2:0] {
		DET_IDLE    = 3'b000,
		DET_CONTACT = 3'b001,
		DET_PRIMARY = 3'b010,
		DET_TO_END  = 3'b011,
		DET_EXIT    = 3'b100,
		DET_DONE    = 3'b101
	} det_state_t;

	typedef struct packed {
		logic active;
		logic source_sink_on;
		logic contact_timeout;
		logic done;
	} det_status_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_t;

endpackage

// >>> battery_charge_port_power.sv
// Charger detection sequencer and downstream port power arbitration.
// Assumes the hub core supplies stage, configuration and enumeration levels
// synchronous to core_clk_i; only overcurrent pins come from off chip.
`timescale 1ns/1ps
module battery_charge_port_power #(
	parameter int          NUM_PORTS        = 3,
	parameter logic [7:0]  CHARGE_EN_RESET  = batt_chg_pkg::CHARGE_PORT_ENABLE_RESET,
	parameter int unsigned CONTACT_TOUT_CYC = batt_chg_pkg::CONTACT_DETECT_TIMEOUT_CYC,
	parameter int unsigned SRC_ON_CYC       = batt_chg_pkg::SOURCE_SINK_ON_TIME_CYC,
	parameter int unsigned TO_END_CYC       = batt_chg_pkg::DETECT_TO_END_DELAY_CYC,
	parameter int unsigned EXIT_CYC         = batt_chg_pkg::DISABLED_EXIT_TIME_CYC
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire batt_chg_pkg::cfg_req_t cfg_req_i,
	output logic [7:0]                  cfg_rdata_o,
	input  wire logic                   cfg_done_i,
	input  wire logic                   charger_detect_stage_i,
	input  wire logic                   charger_detect_enable_i,
	input  wire logic                   data_contact_i,
	input  wire logic                   vdat_detect_i,
	output batt_chg_pkg::det_status_t   det_status_o,
	input  wire logic                   port_power_feature_i,
	input  wire logic [NUM_PORTS:1]     hub_port_power_i,
	input  wire logic [NUM_PORTS:1]     overcurrent_sense_low_i,
	input  wire logic [NUM_PORTS:1]     charge_query_i,
	output logic [NUM_PORTS:1]          charge_ack_o,
	output logic [NUM_PORTS:1]          port_power_enable_o,
	output logic [NUM_PORTS:1]          charge_role_o
);
	import batt_chg_pkg::*;

	// -------------------------------------------------------------------
	// Configuration register
	// -------------------------------------------------------------------
	logic [7:0] charge_port_enable_reg;
	logic       cfg_locked_reg;

	// Writes after configuration are dropped so the port role cannot move
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			charge_port_enable_reg <= CHARGE_EN_RESET;
		end else if (cfg_req_i.wr && !cfg_locked_reg &&
			cfg_req_i.addr == CHARGE_PORT_ENABLE_ADDR) begin
			charge_port_enable_reg <= cfg_req_i.wdata;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_rdata_o <= 8'h00;
		end else if (cfg_req_i.addr == CHARGE_PORT_ENABLE_ADDR) begin
			cfg_rdata_o <= charge_port_enable_reg;
		end else begin
			cfg_rdata_o <= 8'h00;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_locked_reg <= 1'b0;
		end else if (cfg_done_i) begin
			cfg_locked_reg <= 1'b1;
		end
	end

	// Role is captured once, on the cycle configuration completes
	logic [NUM_PORTS:1] role_reg;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			role_reg <= '0;
		end else if (cfg_done_i && !cfg_locked_reg) begin
			role_reg <= charge_port_enable_reg[NUM_PORTS:FIRST_PORT_BIT];
		end
	end

	assign charge_role_o = role_reg;

	// -------------------------------------------------------------------
	// Charger detection sequencer
	// -------------------------------------------------------------------
	det_state_t         state_reg;
	det_state_t         state_next;
	logic [TIMER_W-1:0] timer_reg;
	logic [TIMER_W-1:0] timer_next;
	logic               stage_d_reg;
	logic               contact_tout_reg;
	logic               contact_tout_next;
	logic               stage_rise;

	assign stage_rise = charger_detect_stage_i && !stage_d_reg;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage_d_reg <= 1'b0;
		end else begin
			stage_d_reg <= charger_detect_stage_i;
		end
	end

	always_comb begin
		state_next        = state_reg;
		timer_next        = timer_reg + TIMER_W'(1);
		contact_tout_next = contact_tout_reg;
		unique case (state_reg)
			DET_IDLE: begin
				timer_next = '0;
				if (stage_rise) begin
					contact_tout_next = 1'b0;
					state_next = charger_detect_enable_i ? DET_CONTACT : DET_EXIT;
				end
			end
			DET_CONTACT: begin
				if (data_contact_i) begin
					state_next = DET_PRIMARY;
					timer_next = '0;
				end else if (timer_reg >= TIMER_W'(CONTACT_TOUT_CYC - 1)) begin
					contact_tout_next = 1'b1;
					state_next        = DET_PRIMARY;
					timer_next        = '0;
				end
			end
			DET_PRIMARY: begin
				if (timer_reg >= TIMER_W'(SRC_ON_CYC - 1)) begin
					timer_next = '0;
					state_next = vdat_detect_i ? DET_TO_END : DET_DONE;
				end
			end
			DET_TO_END: begin
				if (timer_reg >= TIMER_W'(TO_END_CYC - 1)) begin
					state_next = DET_DONE;
				end
			end
			DET_EXIT: begin
				if (timer_reg >= TIMER_W'(EXIT_CYC - 1)) begin
					state_next = DET_DONE;
				end
			end
			DET_DONE: begin
				timer_next = '0;
				state_next = DET_IDLE;
			end
			default: begin
				timer_next = '0;
				state_next = DET_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg        <= DET_IDLE;
			timer_reg        <= '0;
			contact_tout_reg <= 1'b0;
		end else begin
			state_reg        <= state_next;
			timer_reg        <= timer_next;
			contact_tout_reg <= contact_tout_next;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			det_status_o <= '0;
		end else begin
			det_status_o.active          <= state_next != DET_IDLE && state_next != DET_DONE;
			det_status_o.source_sink_on  <= state_next == DET_PRIMARY;
			det_status_o.contact_timeout <= contact_tout_next;
			det_status_o.done            <= state_next == DET_DONE;
		end
	end

	// -------------------------------------------------------------------
	// Overcurrent synchronisers
	// -------------------------------------------------------------------
	// Reset value is the inactive (high) level so no false trip at release
	logic [NUM_PORTS:1] oc_meta_reg;
	logic [NUM_PORTS:1] oc_sync_reg;
	logic [NUM_PORTS:1] oc_fault;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oc_meta_reg <= '1;
			oc_sync_reg <= '1;
		end else begin
			oc_meta_reg <= overcurrent_sense_low_i;
			oc_sync_reg <= oc_meta_reg;
		end
	end

	assign oc_fault = ~oc_sync_reg;

	// -------------------------------------------------------------------
	// Port power arbitration
	// -------------------------------------------------------------------
	logic [NUM_PORTS:1] chg_ctrl;
	logic [NUM_PORTS:1] oc_latch_reg;
	logic [NUM_PORTS:1] ppe_next;

	// Feature high means enumerated: hub logic owns all power bits
	assign chg_ctrl = role_reg & {NUM_PORTS{!port_power_feature_i}};

	// Latch-off is never cleared except by device reset
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oc_latch_reg <= '0;
		end else begin
			oc_latch_reg <= oc_latch_reg | (oc_fault & chg_ctrl);
		end
	end

	always_comb begin
		for (int i = 1; i <= NUM_PORTS; i++) begin
			if (oc_fault[i]) begin
				ppe_next[i] = 1'b0;
			end else if (chg_ctrl[i]) begin
				ppe_next[i] = cfg_locked_reg && !oc_latch_reg[i];
			end else begin
				ppe_next[i] = hub_port_power_i[i];
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_power_enable_o <= '0;
		end else begin
			port_power_enable_o <= ppe_next;
		end
	end

	// -------------------------------------------------------------------
	// Charging support query answer
	// -------------------------------------------------------------------
	// Standard ports stay silent; no negative reply exists
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			charge_ack_o <= '0;
		end else begin
			charge_ack_o <= charge_query_i & role_reg;
		end
	end

endmodule

// >>> charge_query_dev.sv
// Downstream device model: raises charging queries and can short its port.
// Assumes the bench hands requests over by non-blocking update at the falling edge.
`timescale 1ns/1ps
module charge_query_dev (
	input  wire logic       clk_i,
	input  wire logic [3:1] req_i,
	input  wire logic [3:1] fault_i,
	output logic      [3:1] query_o,
	output logic      [3:1] oc_n_o
);
	initial begin
		query_o = '0;
		oc_n_o  = '1;
	end
	// Launch off the falling edge, clear of the hub's sampling edge
	always @(negedge clk_i) begin
		query_o <= req_i;
		// Sense line has a pull-up: high unless the port is shorted
		oc_n_o  <= ~fault_i;
	end
endmodule

// >>> battery_charge_port_power_chk.sv
// Port-level checks for the charging and port power block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module battery_charge_port_power_chk #(
	parameter int          NUM_PORTS = 3,
	parameter int unsigned EXIT_CYC  = 5
) (
	input wire logic                 core_clk_i,
	input wire logic                 rst_i,
	input wire logic                 charger_detect_stage_i,
	input wire logic                 charger_detect_enable_i,
	input wire batt_chg_pkg::det_status_t det_status_o,
	input wire logic                 port_power_feature_i,
	input wire logic [NUM_PORTS:1]   hub_port_power_i,
	input wire logic [NUM_PORTS:1]   overcurrent_sense_low_i,
	input wire logic [NUM_PORTS:1]   charge_query_i,
	input wire logic [NUM_PORTS:1]   charge_ack_o,
	input wire logic [NUM_PORTS:1]   port_power_enable_o,
	input wire logic [NUM_PORTS:1]   charge_role_o
);
	import batt_chg_pkg::*;
	localparam int EX_LO = EXIT_CYC - 1;
	localparam int EX_HI = EXIT_CYC + 2;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_ack_only_role: assert property (
		charge_ack_o == ($past(charge_query_i) & $past(charge_role_o)))
		else $error("ack differs from query and role");
	a_role_stays_fixed: assert property (charge_role_o != 0 |=> $stable(charge_role_o))
		else $error("port role changed");
	a_oc_clears_power: assert property (
		!overcurrent_sense_low_i[1] [*3] |=> !port_power_enable_o[1])
		else $error("power kept during overcurrent");
	a_latch_holds_off: assert property ($fell(port_power_enable_o[1]) && charge_role_o[1]
		&& !port_power_feature_i && !$past(port_power_feature_i) |=> !port_power_enable_o[1])
		else $error("charging power came back");
	a_charge_power_on: assert property (overcurrent_sense_low_i[1] [*4] ##0
		($rose(charge_role_o[1]) && !port_power_feature_i) |=> port_power_enable_o[1])
		else $error("charging port not powered");
	a_hub_takes_over: assert property (overcurrent_sense_low_i[1] [*4] ##0 port_power_feature_i
		|=> port_power_enable_o[1] == $past(hub_port_power_i[1]))
		else $error("power ignores hub logic");
	a_detect_starts: assert property ($rose(charger_detect_stage_i)
		&& !det_status_o.active && !det_status_o.done |=> det_status_o.active)
		else $error("detection did not start");
	a_disabled_exit: assert property ($rose(det_status_o.active)
		&& !$past(charger_detect_enable_i) |-> ##[EX_LO:EX_HI] det_status_o.done)
		else $error("disabled exit time wrong");
	a_source_in_active: assert property (det_status_o.source_sink_on |-> det_status_o.active)
		else $error("source on outside detection");
endmodule
bind battery_charge_port_power battery_charge_port_power_chk #(
	.NUM_PORTS(NUM_PORTS), .EXIT_CYC(EXIT_CYC)) u_chk (.core_clk_i, .rst_i,
	.charger_detect_stage_i, .charger_detect_enable_i, .det_status_o, .port_power_feature_i,
	.hub_port_power_i, .overcurrent_sense_low_i, .charge_query_i, .charge_ack_o,
	.port_power_enable_o, .charge_role_o);

// >>> battery_charge_port_power_tb.sv
// Self-checking bench for the charging and port power block.
// Assumes shortened detection counts; the device model sits on the port side.
`timescale 1ns/1ps
module battery_charge_port_power_tb;
	import batt_chg_pkg::*;
	localparam int CT = 20, SO = 8, TE = 8, EX = 5;
	logic clk = 0, rst = 1, cdone = 0, stg = 0, den = 0, dc = 0, vd = 1, feat = 0;
	logic [3:1] hub = 0, qreq = 0, flt = 0, q, oc_n, ack, pe, role, v;
	logic [7:0] rd, w;
	cfg_req_t cfg = '0;
	det_status_t st;
	int num_errors = 0, checks_done = 0, n, son;
	initial forever #4 clk = ~clk;
	charge_query_dev P (.clk_i(clk), .req_i(qreq), .fault_i(flt), .query_o(q), .oc_n_o(oc_n));
	battery_charge_port_power #(.CONTACT_TOUT_CYC(CT), .SRC_ON_CYC(SO), .TO_END_CYC(TE),
		.EXIT_CYC(EX)) DUT (.core_clk_i(clk), .rst_i(rst), .cfg_req_i(cfg), .cfg_rdata_o(rd),
		.cfg_done_i(cdone), .charger_detect_stage_i(stg), .charger_detect_enable_i(den),
		.data_contact_i(dc), .vdat_detect_i(vd), .det_status_o(st), .port_power_feature_i(feat),
		.hub_port_power_i(hub), .overcurrent_sense_low_i(oc_n), .charge_query_i(q),
		.charge_ack_o(ack), .port_power_enable_o(pe), .charge_role_o(role));
	function logic [3:1] pexp(input logic [3:1] h, c, dead);
		return (c & ~dead) | (h & ~c);
	endfunction
	function int dlen(input int e);
		return e == 0 ? EX : e == 1 ? CT + SO + TE : 1 + SO;
	endfunction
	task chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Write pulse, then hold the address so the read-back lands
	task wr(input logic [7:0] a, d);
		cfg = '{1'b1, a, d};
		tick(1);
		cfg.wr = 1'b0;
		tick(1);
	endtask
	task summarize;
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		summarize;
	end
	initial begin
		n = $urandom(1688);
		tick(16);
		rst = 0;
		w = 8'($urandom) | 8'h02;
		wr(8'h33, 8'hff); chk(rd, 8'h00);
		wr(CHARGE_PORT_ENABLE_ADDR, w); chk(rd, w);
		chk(pe, 0);
		cdone = 1;
		tick(1);
		cdone = 0;
		// Late loads must be ignored, so roles cannot move
		wr(CHARGE_PORT_ENABLE_ADDR, 8'h00); chk(rd, w);
		chk(role, w[3:1]);
		repeat (8) begin
			hub = 3'($urandom);
			tick(2); chk(pe, pexp(hub, w[3:1], 0));
		end
		repeat (16) begin
			v = 3'($urandom);
			qreq <= v;
			tick(2); chk(ack, v & w[3:1]);
		end
		flt <= 3'b001;
		tick(5);
		flt <= 3'b000;
		tick(5); chk(pe, pexp(hub, w[3:1], 3'b001));
		feat = 1;
		repeat (6) begin
			hub = 3'($urandom);
			tick(2); chk(pe, hub);
		end
		hub = 3'b111;
		flt <= 3'b010;
		tick(5); chk(pe, 3'b101);
		flt <= 3'b000;
		tick(5); chk(pe, 3'b111);
		feat = 0;
		tick(2); chk(pe, 3'b110);
		// Pass 0 disabled, pass 1 contact timeout, pass 2 early contact and no comparator trip
		for (int e = 0; e < 3; e++) begin
			den = e != 0;
			dc = e == 2;
			vd = e != 2;
			stg = 1;
			n = 0;
			son = 0;
			while (st.done !== 1'b1 && n < 100) begin
				tick(1);
				n++;
				son += st.source_sink_on;
			end
			stg = 0;
			chk(n inside {[dlen(e) - 1:dlen(e) + 3]}, 1);
			chk(8'(son), 8'(e ? SO : 0));
			chk(st.contact_timeout, e == 1);
			tick(2);
		end
		dc = 0;
		rst = 1;
		tick(2); chk(pe, 0);
		// Only a full reset may bring a latched-off charging port back
		rst = 0;
		hub = 3'b000;
		tick(2); chk(pe, 0);
		wr(CHARGE_PORT_ENABLE_ADDR, 8'h02);
		cdone = 1;
		tick(1);
		cdone = 0;
		tick(2); chk(pe, 3'b001);
		summarize;
	end
endmodule
